// >>> verilog/pllcs_top.v
// Core clock source selection, PLL lock sequencing and register slave.
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "pllcs_defines.vh"

// Functional notes
// - Source field 00 gives reference/2, 01 the reference, 10 or 11 the PLL.
// - The PLL is powered only while the upper source bit is one.
// - A lock counter runs after PLL enable and gates the switch to the PLL.
// - Power-on reset clears the lock counter.
// - The locked flag sets on counter rollover and requests the PLL; core_on_pll follows at the hand-over.
// - The three-bit multiplier field picks a factor of 1, 2, 3, 4, 5 or 9.
// - The input-halve bit divides the PLL input by two before multiplication.
// - The locked core rate is reference times factor, halved when halving.
// - With the bypass pin low the external clock is used and the oscillator is off.
// - With the bypass pin high the crystal oscillator runs between the two pins.
// - The crystal oscillator is trusted only about 1 ms after it starts.
// - Reset clears the source, multiplier and halve fields, starting on reference/2.
// - On rollover the core clock moves to the PLL automatically and glitch free.
// - Multiplier and halve changes wait until the PLL is deselected and re-enabled.
module pllcs_top #(
  parameter        LOCK_CNT_W    = `PLLCS_LOCK_CNT_W,
  parameter        OSC_CNT_W     = `PLLCS_OSC_CNT_W,
  parameter        OSC_START_CYC = `PLLCS_OSC_START_CYC,
  parameter [31:0] FACTOR_MAP    = `PLLCS_FACTOR_MAP
) (
  // Clock, reset and clock enable
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // Oscillator pins
  input  wire        osc_bypass_n,
  input  wire        crystal_in_ext_clock,
  output reg         crystal_out,
  output reg         osc_power_down,
  output reg         osc_ready,
  // PLL macro
  input  wire        pll_clock,
  output reg         pll_power_up,
  output reg  [3:0]  pll_factor,
  output reg         pll_ref_halve,
  output reg  [4:0]  pll_ratio_half,
  // Core clock
  output wire        core_clock,
  output wire        core_on_pll,
  // Interrupt
  output reg         irq
);

  // The last start-up count is cut to the counter width on purpose; OSC_CNT_W
  // must be chosen wide enough to hold OSC_START_CYC, or the wait comes short.
  localparam integer         OSC_LAST_I = OSC_START_CYC - 1;
  localparam [OSC_CNT_W-1:0] OSC_LAST   = OSC_LAST_I[OSC_CNT_W-1:0];

  // Software visible state.
  reg  [1:0]            clock_source_select;
  reg  [2:0]            pll_multiplier_select;
  reg                   pll_input_halve;
  reg                   pll_locked_flag;
  reg  [`PLLCS_EV_W-1:0] irq_status;
  reg  [`PLLCS_EV_W-1:0] irq_mask;

  // Internal state.
  reg  [LOCK_CNT_W-1:0] lock_cnt;
  reg  [OSC_CNT_W-1:0]  osc_cnt;
  reg                   osc_mode_d;
  reg  [2:0]            mult_applied;
  reg                   halve_applied;
  reg                   pll_en_d;
  reg                   ref_d;
  reg                   ref_div2;
  reg                   dp_wr;
  reg  [31:0]           dp_addr;

  // Combinational terms.
  reg  [31:0]           rd_mux;
  reg  [`PLLCS_EV_W-1:0] events;
  reg  [`PLLCS_EV_W-1:0] w1c;
  reg  [`PLLCS_EV_W-1:0] next_status;
  reg  [1:0]            sel_req;
  reg  [3:0]            next_factor;

  wire                  ahb_take;
  wire                  pll_en;
  wire                  pll_run;
  wire                  lock_roll;
  wire                  ref_live;
  wire                  osc_start;
  wire                  osc_done;
  wire                  wr_first;
  wire                  wr_second;
  wire                  wr_status;
  wire                  wr_mask;

  assign ahb_take = ce & hsel & hready & htrans[1];
  assign wr_first  = dp_wr & (dp_addr == `PLLCS_ADDR(`PLLCS_IDX_CTRL_FIRST));
  assign wr_second = dp_wr & (dp_addr == `PLLCS_ADDR(`PLLCS_IDX_CTRL_SECOND));
  assign wr_status = dp_wr & (dp_addr == `PLLCS_ADDR(`PLLCS_IDX_IRQ_STATUS));
  assign wr_mask   = dp_wr & (dp_addr == `PLLCS_ADDR(`PLLCS_IDX_IRQ_MASK));

  assign pll_en  = clock_source_select[1];
  assign pll_run = pll_en & pll_en_d & osc_ready;
  assign lock_roll = pll_run & ~pll_locked_flag & (&lock_cnt);

  // The reference counts as absent until the oscillator is trusted, so no
  // counter or divider runs on a crystal that has not settled.
  assign ref_live  = osc_ready & crystal_in_ext_clock;
  assign osc_start = osc_bypass_n & ~osc_mode_d;
  assign osc_done  = osc_bypass_n & ~osc_start & ~osc_ready & (osc_cnt == OSC_LAST);

  // Register read data, sampled in the address phase.
  always @* begin
    rd_mux = 32'h0000_0000;
    if (haddr == `PLLCS_ADDR(`PLLCS_IDX_CTRL_FIRST)) begin
      rd_mux[`PLLCS_SRC_HI:`PLLCS_SRC_LO] = clock_source_select;
      rd_mux[`PLLCS_LOCK_BIT]             = pll_locked_flag;
    end else if (haddr == `PLLCS_ADDR(`PLLCS_IDX_CTRL_SECOND)) begin
      rd_mux[`PLLCS_MULT_HI:`PLLCS_MULT_LO] = pll_multiplier_select;
      rd_mux[`PLLCS_HALVE_BIT]              = pll_input_halve;
    end else if (haddr == `PLLCS_ADDR(`PLLCS_IDX_IRQ_STATUS)) begin
      rd_mux[`PLLCS_EV_W-1:0] = irq_status;
    end else if (haddr == `PLLCS_ADDR(`PLLCS_IDX_IRQ_MASK)) begin
      rd_mux[`PLLCS_EV_W-1:0] = irq_mask;
    end else if (haddr == `PLLCS_ADDR(`PLLCS_IDX_STATE)) begin
      rd_mux[`PLLCS_ST_OSC]    = osc_ready;
      rd_mux[`PLLCS_ST_ON_PLL] = core_on_pll;
      rd_mux[`PLLCS_ST_PWR]    = pll_power_up;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY. Nothing here ever needs a
  // wait, so hreadyout stays high; a transfer made while ce is low is lost.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      dp_wr     <= 1'b0;
      dp_addr   <= 32'h0000_0000;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dp_wr     <= ahb_take & hwrite;
      if (ahb_take) begin
        dp_addr <= haddr;
        if (!hwrite) begin
          hrdata <= rd_mux;
        end
      end
    end
  end

  // Control registers. Settings written while the PLL runs are stored and read
  // back at once, but reach the PLL only at its next enable.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_source_select   <= `PLLCS_RST_SRC;
      pll_multiplier_select <= `PLLCS_RST_MULT;
      pll_input_halve       <= `PLLCS_RST_HALVE;
      irq_mask              <= `PLLCS_RST_MASK;
    end else if (ce) begin
      if (wr_first) begin
        clock_source_select <= hwdata[`PLLCS_SRC_HI:`PLLCS_SRC_LO];
      end
      if (wr_second) begin
        pll_multiplier_select <= hwdata[`PLLCS_MULT_HI:`PLLCS_MULT_LO];
        pll_input_halve       <= hwdata[`PLLCS_HALVE_BIT];
      end
      if (wr_mask) begin
        irq_mask <= hwdata[`PLLCS_EV_W-1:0];
      end
    end
  end

  // Oscillator control.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_mode_d     <= 1'b0;
      osc_cnt        <= {OSC_CNT_W{1'b0}};
      osc_ready      <= 1'b0;
      osc_power_down <= 1'b1;
      crystal_out    <= 1'b0;
    end else if (ce) begin
      osc_mode_d <= osc_bypass_n;
      if (!osc_bypass_n) begin
        osc_power_down <= 1'b1;
        crystal_out    <= 1'b0;
        osc_cnt        <= {OSC_CNT_W{1'b0}};
        osc_ready      <= 1'b1;
      end else begin
        osc_power_down <= 1'b0;
        crystal_out    <= ~crystal_in_ext_clock;
        if (osc_start) begin
          osc_cnt   <= {OSC_CNT_W{1'b0}};
          osc_ready <= 1'b0;
        end else if (osc_done) begin
          osc_ready <= 1'b1;
        end else if (!osc_ready) begin
          osc_cnt <= osc_cnt + 1'b1;
        end
      end
    end
  end

  // Reference divider by two.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_d    <= 1'b0;
      ref_div2 <= 1'b0;
    end else if (ce) begin
      ref_d <= ref_live;
      if (ref_live && !ref_d) begin
        ref_div2 <= ~ref_div2;
      end
    end
  end

  // PLL power, applied settings and lock sequencing. The counter runs only
  // while the reference is trusted: a crystal that has not settled gives the
  // PLL nothing to lock to, and counting then would end the wait too early.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_cnt        <= {LOCK_CNT_W{1'b0}};
      pll_locked_flag <= 1'b0;
      pll_en_d        <= 1'b0;
      pll_power_up    <= 1'b0;
      mult_applied    <= `PLLCS_RST_MULT;
      halve_applied   <= `PLLCS_RST_HALVE;
    end else if (ce) begin
      pll_en_d     <= pll_en;
      pll_power_up <= pll_en;
      if (!pll_en) begin
        lock_cnt        <= {LOCK_CNT_W{1'b0}};
        pll_locked_flag <= 1'b0;
      end else if (!pll_en_d) begin
        mult_applied  <= pll_multiplier_select;
        halve_applied <= pll_input_halve;
        lock_cnt      <= {LOCK_CNT_W{1'b0}};
      end else if (pll_run && !pll_locked_flag) begin
        lock_cnt <= lock_cnt + 1'b1;
        if (lock_roll) begin
          pll_locked_flag <= 1'b1;
        end
      end
    end
  end

  always @* begin
    next_factor = FACTOR_MAP[{mult_applied, 2'b00} +: 4];
  end

  // Settings presented to the PLL macro. The ratio is carried in half steps so
  // that the factors of a halved input stay whole numbers.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_factor     <= 4'h0;
      pll_ref_halve  <= 1'b0;
      pll_ratio_half <= 5'h00;
    end else if (ce) begin
      pll_factor     <= next_factor;
      pll_ref_halve  <= halve_applied;
      pll_ratio_half <= halve_applied ? {1'b0, next_factor} : {next_factor, 1'b0};
    end
  end

  // While the PLL locks, code 10 keeps reference/2 and code 11 the
  // reference itself, so the core never stops during the wait.
  always @* begin
    if (pll_locked_flag) begin
      sel_req = `PLLCS_SRC_PLL;
    end else if (clock_source_select[0]) begin
      sel_req = `PLLCS_SRC_DIRECT;
    end else begin
      sel_req = `PLLCS_SRC_DIV2;
    end
  end

  pllcs_clock_switch u_switch (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .src_div2   (ref_div2),
    .src_direct (ref_live),
    .src_pll    (pll_clock),
    .sel_req    (sel_req),
    .clk_out    (core_clock),
    .on_pll     (core_on_pll)
  );

  // Interrupt events and sticky status.
  always @* begin
    events                 = {`PLLCS_EV_W{1'b0}};
    events[`PLLCS_EV_LOCK] = lock_roll;
    events[`PLLCS_EV_OSC]  = osc_done;
    // Deselecting a locked PLL is reported, since the core then falls back to
    // the slower reference clocks without any other notice.
    events[`PLLCS_EV_DROP] = pll_locked_flag & ~pll_en;
    w1c                    = wr_status ? hwdata[`PLLCS_EV_W-1:0] : {`PLLCS_EV_W{1'b0}};
    // An event in the cycle of its clear wins, so none is lost.
    next_status            = (irq_status & ~w1c) | events;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= {`PLLCS_EV_W{1'b0}};
      irq        <= 1'b0;
    end else if (ce) begin
      irq_status <= next_status;
      // Taken from next_status so that irq rises in the cycle its bit sets.
      irq        <= |(next_status & irq_mask);
    end
  end

endmodule

// >>> verilog/pllcs_defines.vh
// Shared constants of the PLL clock source select block.
`ifndef PLLCS_DEFINES_VH
`define PLLCS_DEFINES_VH

// Clock rate and timing figures.
`define PLLCS_HCLK_MHZ        200
`define PLLCS_OSC_START_US    1000
`define PLLCS_OSC_START_CYC   (`PLLCS_OSC_START_US * `PLLCS_HCLK_MHZ)
`define PLLCS_OSC_CNT_W       18
`define PLLCS_LOCK_TIME_US    100
`define PLLCS_LOCK_CNT_W      15

// Register indexes; the byte address is four times the index.
`define PLLCS_IDX_CTRL_FIRST  16'h702a
`define PLLCS_IDX_CTRL_SECOND 16'h702c
`define PLLCS_IDX_IRQ_STATUS  16'h7030
`define PLLCS_IDX_IRQ_MASK    16'h7032
`define PLLCS_IDX_STATE       16'h7034
`define PLLCS_ADDR(idx)       {14'h0000, idx, 2'b00}

// Fields of clock_ctrl_first.
`define PLLCS_SRC_HI          7
`define PLLCS_SRC_LO          6
`define PLLCS_LOCK_BIT        4

// Fields of clock_ctrl_second.
`define PLLCS_MULT_HI         2
`define PLLCS_MULT_LO         0
`define PLLCS_HALVE_BIT       3

// Interrupt status and mask bits.
`define PLLCS_EV_LOCK         0
`define PLLCS_EV_OSC          1
`define PLLCS_EV_DROP         2
`define PLLCS_EV_W            3

// Fields of the state register.
`define PLLCS_ST_OSC          0
`define PLLCS_ST_ON_PLL       1
`define PLLCS_ST_PWR          2

// Reset values.
`define PLLCS_RST_SRC         2'b00
`define PLLCS_RST_MULT        3'h0
`define PLLCS_RST_HALVE       1'b0
`define PLLCS_RST_MASK        3'h0

// Core clock source codes.
`define PLLCS_SRC_DIV2        2'b00
`define PLLCS_SRC_DIRECT      2'b01
`define PLLCS_SRC_PLL         2'b10

// Factor per multiplier code, one nibble per code, code 0 lowest.
`define PLLCS_FACTOR_MAP      32'h9995_4321

`endif

// >>> verilog/pllcs_clock_switch.v
// Glitch-free selector that hands the core clock between its three sources.
`timescale 1ns/1ps
`include "pllcs_defines.vh"

module pllcs_clock_switch (
  // Clock, reset and clock enable
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       ce,
  // Source levels and requested source
  input  wire       src_div2,
  input  wire       src_direct,
  input  wire       src_pll,
  input  wire [1:0] sel_req,
  // Selected clock
  output reg        clk_out,
  output reg        on_pll
);

  reg  [1:0] sel_cur;
  reg        cur_lvl;
  reg        req_lvl;
  reg  [1:0] next_sel;

  always @* begin
    cur_lvl = src_div2;
    req_lvl = src_div2;
    if (sel_cur == `PLLCS_SRC_DIRECT) begin
      cur_lvl = src_direct;
    end else if (sel_cur[1]) begin
      cur_lvl = src_pll;
    end
    if (sel_req == `PLLCS_SRC_DIRECT) begin
      req_lvl = src_direct;
    end else if (sel_req[1]) begin
      req_lvl = src_pll;
    end
  end

  // The hand-over waits until both the running and the new source are low,
  // so the output never shows a pulse shorter than either source gives.
  always @* begin
    next_sel = sel_cur;
    if ((sel_req != sel_cur) && !clk_out && !req_lvl) begin
      next_sel = sel_req;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_cur <= `PLLCS_SRC_DIV2;
      clk_out <= 1'b0;
      on_pll  <= 1'b0;
    end else if (ce) begin
      sel_cur <= next_sel;
      clk_out <= (next_sel != sel_cur) ? 1'b0 : cur_lvl;
      on_pll  <= next_sel[1];
    end
  end

endmodule

// >>> sim/pllcs_checker_assertions.sv
// Port checks of the clock source select block.
`timescale 1ns/1ps
module pllcs_checker #(
  parameter int OSC_START_CYC = 10,
  parameter int LOCK_CNT_W    = 4
) (
  // Clock and reset
  input wire       hclk,
  input wire       hresetn,
  // Oscillator
  input wire       osc_bypass_n,
  input wire       crystal_in_ext_clock,
  input wire       crystal_out,
  input wire       osc_power_down,
  input wire       osc_ready,
  // PLL and core clock
  input wire       pll_clock,
  input wire       pll_power_up,
  input wire [3:0] pll_factor,
  input wire       pll_ref_halve,
  input wire       core_clock,
  input wire       core_on_pll
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int osc_cnt;
  int pwr_cnt;
  // Cycles in crystal mode and cycles with the PLL powered.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt <= 0;
      pwr_cnt <= 0;
    end else begin
      osc_cnt <= osc_bypass_n ? osc_cnt + 1 : 0;
      pwr_cnt <= pll_power_up ? pwr_cnt + 1 : 0;
    end
  end
  sequence s_on3;
    core_on_pll [*3];
  endsequence
  sequence s_leave;
    ##[0:16] !core_on_pll;
  endsequence
  property p_bypass;
    !osc_bypass_n && !$past(osc_bypass_n) && $past(hresetn) |-> osc_power_down && osc_ready;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass state wrong");
  property p_osc_run;
    osc_bypass_n && $past(osc_bypass_n) && $past(hresetn)
      |-> !osc_power_down && crystal_out == !$past(crystal_in_ext_clock);
  endproperty
  a_osc_run: assert property (p_osc_run) else $error("crystal drive wrong");
  property p_osc_early;
    osc_bypass_n && osc_ready |-> osc_cnt >= OSC_START_CYC - 1;
  endproperty
  a_osc_early: assert property (p_osc_early) else $error("oscillator ready early");
  property p_osc_late;
    osc_bypass_n && osc_cnt == OSC_START_CYC + 4 |-> osc_ready;
  endproperty
  a_osc_late: assert property (p_osc_late) else $error("oscillator ready late");
  property p_lock_gate;
    $rose(core_on_pll) |-> pwr_cnt >= (1 << LOCK_CNT_W);
  endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("switch before lock");
  property p_leave;
    $fell(pll_power_up) |-> s_leave;
  endproperty
  a_leave: assert property (p_leave) else $error("still on PLL");
  property p_on_src;
    s_on3 |-> core_clock == $past(pll_clock);
  endproperty
  a_on_src: assert property (p_on_src) else $error("core not from PLL");
  property p_hold;
    core_on_pll && $past(core_on_pll) |-> $stable(pll_factor) && $stable(pll_ref_halve);
  endproperty
  a_hold: assert property (p_hold) else $error("settings changed on PLL");
endmodule

bind pllcs_top pllcs_checker #(.OSC_START_CYC(OSC_START_CYC), .LOCK_CNT_W(LOCK_CNT_W))
  i_chk (.hclk, .hresetn, .osc_bypass_n, .crystal_in_ext_clock, .crystal_out,
  .osc_power_down, .osc_ready, .pll_clock, .pll_power_up, .pll_factor, .pll_ref_halve,
  .core_clock, .core_on_pll);

// >>> sim/pllcs_ref_model.sv
// Reference source on the oscillator pins: crystal or external clock.
`timescale 1ns/1ps
module pllcs_ref_model #(
  parameter int HALF = 3
) (
  // Clock and mode
  input wire hclk,
  input wire osc_bypass_n,
  input wire osc_power_down,
  // Reference level
  output logic ref_level
);
  int cnt = 0;
  initial ref_level = 1'h0;
  always @(posedge hclk) begin
    if (!osc_bypass_n || !osc_power_down) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) ref_level <= ~ref_level;
    end
  end
endmodule

// >>> sim/pll_clock_source_select_test.sv
// Self-checking bench of the clock source select block.
`timescale 1ns/1ps
`include "pllcs_defines.vh"
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
`define WAITFOR(c, lim) begin k = 0; while (!(c) && k < lim) begin @(negedge hclk); k++; \
  end if (!(c)) begin n_errors++; wrap_up; end end
module pll_clock_source_select_test;
  typedef struct {int src, c2, mk, st, lk;} pllcs_model_t;
  localparam logic [31:0] a_c0 = `PLLCS_ADDR(`PLLCS_IDX_CTRL_FIRST);
  localparam logic [31:0] a_c1 = `PLLCS_ADDR(`PLLCS_IDX_CTRL_SECOND);
  localparam logic [31:0] a_st = `PLLCS_ADDR(`PLLCS_IDX_IRQ_STATUS);
  localparam logic [31:0] a_mk = `PLLCS_ADDR(`PLLCS_IDX_IRQ_MASK);
  localparam logic [31:0] a_sv = `PLLCS_ADDR(`PLLCS_IDX_STATE);
  localparam logic [31:0] a_un = `PLLCS_ADDR(16'h702e);
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, osc_bypass_n = 1, pll_clock = 0, h;
  logic [31:0] haddr = 0, hwdata = 0, rdat;
  logic [1:0]  htrans = 0;
  wire         hreadyout, hresp, crystal_in_ext_clock, crystal_out, osc_power_down;
  wire         osc_ready, pll_power_up, pll_ref_halve, core_clock, core_on_pll, irq;
  wire  [31:0] hrdata;
  wire  [3:0]  pll_factor;
  wire  [4:0]  pll_ratio_half;
  int          n_errors = 0, comparisons = 0, k;
  pllcs_model_t m;
  initial forever #2.5 hclk = ~hclk;
  // The PLL output runs at half the bus clock in this bench.
  always @(posedge hclk) pll_clock <= ~pll_clock;
  pllcs_top #(.LOCK_CNT_W(4), .OSC_START_CYC(10)) i_dut (
    .hclk, .hresetn, .ce(1'h1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .osc_bypass_n, .crystal_in_ext_clock,
    .crystal_out, .osc_power_down, .osc_ready, .pll_clock, .pll_power_up, .pll_factor,
    .pll_ref_halve, .pll_ratio_half, .core_clock, .core_on_pll, .irq);
  pllcs_ref_model i_ref (.hclk, .osc_bypass_n, .osc_power_down,
    .ref_level(crystal_in_ext_clock));
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic hold;
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'h1 && k < 50);
    if (k >= 50) begin n_errors++; wrap_up; end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hold;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    hold;
    rdat = hrdata;
  endtask
  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    case (a)
      a_c0: return 32'(m.src << 6 | m.lk << 4);
      a_c1: return 32'(m.c2);
      a_st: return 32'(m.st);
      a_mk: return 32'(m.mk);
      a_sv: return 32'(m.lk << 1 | (m.src >> 1) << 2 | 1);
      default: return 32'h0;
    endcase
  endfunction
  task automatic rd(input logic [31:0] a, input string n);
    bus(1'h0, a, 32'h0);
    `CHK(n, exp_rd(a), rdat)
    `CHK("hresp", 1'h0, hresp)
  endtask
  function automatic int fac(input int c);
    return c < 5 ? c + 1 : 9;
  endfunction
  // Counts rising edges of source and core over a window; div is source per core.
  task automatic rate(input int div, input logic usepll, input string n);
    int rr = 0;
    int cc = 0;
    logic ps;
    logic pc;
    // Start from the present levels, so a high level is not counted as an edge.
    ps = usepll ? pll_clock : crystal_in_ext_clock;
    pc = core_clock;
    repeat (120) begin
      @(negedge hclk);
      rr += int'((usepll ? pll_clock : crystal_in_ext_clock) & !ps);
      cc += int'(core_clock & !pc);
      ps = usepll ? pll_clock : crystal_in_ext_clock;
      pc = core_clock;
    end
    `CHK(n, 1'h1, 1'(rr - div * cc <= div && rr - div * cc >= -div))
  endtask
  initial begin
    void'($urandom(32'hcf2a));
    m = '{default: 0};
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    @(negedge hclk);
    `CHK("osc_ready", 1'h0, osc_ready)
    `WAITFOR(osc_ready === 1'h1, 40)
    m.st = 2;
    rd(a_c0, "ctrl_first");
    rd(a_c1, "ctrl_second");
    rd(a_st, "status");
    rd(a_mk, "mask");
    rd(a_un, "unmapped");
    bus(1'h1, a_st, 32'h7);
    m.st = 0;
    rd(a_st, "status_w1c");
    $display("Test reset done");
    for (int s = 0; s < 2; s++) begin
      bus(1'h1, a_c0, 32'(s << 6));
      m.src = s;
      rd(a_c0, "src");
      `CHK("pll_power_up", 1'h0, pll_power_up)
      // Let the switch finish its hand-over before the rates are compared.
      repeat (16) @(negedge hclk);
      rate(2 - s, 1'h0, "ref_rate");
    end
    $display("Test bypass sources done");
    for (int i = 0; i < 8; i++) begin
      // every multiplier code is tried once, each with a random input-halve bit
      h = 1'($urandom);
      m.c2 = {h, 3'(i)};
      bus(1'h1, a_c1, 32'(m.c2));
      m.mk = i == 7 ? 0 : 5;
      bus(1'h1, a_mk, 32'(m.mk));
      m.src = 2 | (i & 1);
      bus(1'h1, a_c0, 32'(m.src << 6));
      rd(a_c0, "lock_early");
      `CHK("on_pll_early", 1'h0, core_on_pll)
      `CHK("pll_power_up", 1'h1, pll_power_up)
      `WAITFOR(core_on_pll === 1'h1, 300)
      m.lk = 1;
      m.st = 1;
      rd(a_c0, "lock_flag");
      rd(a_sv, "state");
      `CHK("factor", 4'(fac(i)), pll_factor)
      `CHK("halve", h, pll_ref_halve)
      `CHK("ratio", 5'(h ? fac(i) : 2 * fac(i)), pll_ratio_half)
      `CHK("irq_lock", 1'((m.st & m.mk) != 0), irq)
      m.c2 = ~m.c2 & 15;
      bus(1'h1, a_c1, 32'(m.c2));
      rd(a_c1, "c2_readback");
      `CHK("factor_held", 4'(fac(i)), pll_factor)
      rate(1, 1'h1, "pll_rate");
      bus(1'h1, a_st, 32'h1);
      m.st = 0;
      repeat (2) @(negedge hclk);
      `CHK("irq_clear", 1'h0, irq)
      bus(1'h1, a_c0, 32'h0);
      m.src = 0;
      m.lk = 0;
      m.st = 4;
      `WAITFOR(core_on_pll === 1'h0, 40)
      rd(a_sv, "state_off");
      rd(a_st, "drop");
      `CHK("irq_drop", 1'((m.st & m.mk) != 0), irq)
      bus(1'h1, a_st, 32'h7);
      m.st = 0;
    end
    $display("Test lock sequence done");
    hresetn <= 1'h0;
    osc_bypass_n <= 1'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    m = '{default: 0};
    repeat (3) @(negedge hclk);
    `CHK("osc_power_down", 1'h1, osc_power_down)
    `CHK("osc_ready_ext", 1'h1, osc_ready)
    rd(a_c1, "c2_reset");
    rate(2, 1'h0, "ext_rate");
    $display("Test external clock done");
    wrap_up;
  end
endmodule
